// ==== pci_interrupt_line_router.sv ====
// What this block does
// - legacy mode drives only IRQ 0 to 15, sixteen outputs.
// - advanced mode drives twenty-four IRQ outputs, 0 to 23.
// - exactly eight shared request lines, a to h, take every slot, serial-bus and onboard source.
// - legacy steering picks one IRQ from 3-7, 9-12, 14, 15 only.
// - several lines may share an IRQ; it is the OR of its lines.
// - advanced mode drives IRQ 16 to 23 straight from lines a to h.
// - IRQ 2 is the cascade input and never takes a request line.
// - IRQ 0, 1, 8, 13 are fixed sources, never steered.
// - slot wiring: slot1 A-D to f,g,h,e; slot2 A-D to g,f,e,h; serial bus A to b.
// - sources tied to one line share it; line asserted while any source is.
// - onboard dynamic sources steer onto lines through run-time select inputs.
`timescale 1ns/1ps
`include "irq_router_defs.svh"

module pci_interrupt_line_router (
  input  wire logic                           clk,             // 100 MHz clock
  input  wire logic                           rst,             // async reset, active high
  input  wire logic [`CARD_PIN_COUNT-1:0]     slot1_int,       // slot 1 pins A..D, active high
  input  wire logic [`CARD_PIN_COUNT-1:0]     slot2_int,       // slot 2 pins A..D, active high
  input  wire logic                           serial_bus_int,  // serial-bus controller pin A
  input  wire logic [`LINE_COUNT-1:0]         onboard_int,     // dynamic onboard sources
  input  wire logic [3*`LINE_COUNT-1:0]       onboard_sel,     // line choice per onboard source
  input  wire logic                           mode_adv,        // 1 selects advanced mode
  input  wire logic [`STEER_W*`LINE_COUNT-1:0] steer_cfg,      // IRQ per line, legacy mode
  input  wire logic                           steer_wr,        // load steer_cfg and mode_adv
  input  wire logic [`LEGACY_IRQ_COUNT-1:0]   fixed_irq,       // legacy sources on fixed IRQs
  output logic      [`ADV_IRQ_COUNT-1:0]      irq_out,         // IRQ lines to controller
  output logic      [`LINE_COUNT-1:0]         line_state,      // request lines a..h
  output logic      [`STEER_W*`LINE_COUNT-1:0] steer_state,    // held steering fields
  output logic                                mode_state       // held mode
);

  localparam int NL = `LINE_COUNT;
  localparam logic [15:0] ALLOWED  = `STEER_ALLOWED;
  localparam logic [15:0] RESERVED = `RESERVED_MASK;

  // pin inputs pass three flops; a change counts when stages two and three agree
  logic [NL-1:0] raw_line;
  logic [NL-1:0] sync1_reg, sync2_reg, sync3_reg, line_reg;

  logic [NL-1:0] dyn_line;
  always_comb begin
    dyn_line = '0;
    for (int s = 0; s < NL; s++) begin
      if (onboard_int[s]) begin
        dyn_line[onboard_sel[3*s +: 3]] = 1'b1;
      end
    end
  end

  // board wiring is fixed; sources on one line are wire-ORed
  always_comb begin
    raw_line    = dyn_line;
    raw_line[1] = raw_line[1] | serial_bus_int;
    raw_line[5] = raw_line[5] | slot1_int[0] | slot2_int[1];
    raw_line[6] = raw_line[6] | slot1_int[1] | slot2_int[0];
    raw_line[7] = raw_line[7] | slot1_int[2] | slot2_int[3];
    raw_line[4] = raw_line[4] | slot1_int[3] | slot2_int[2];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      line_reg  <= '0;
    end else begin
      sync1_reg <= raw_line;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < NL; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          line_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // fixed sources take the same filter
  logic [15:0] fx1_reg, fx2_reg, fx3_reg, fx_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fx1_reg <= '0;
      fx2_reg <= '0;
      fx3_reg <= '0;
      fx_reg  <= '0;
    end else begin
      fx1_reg <= fixed_irq;
      fx2_reg <= fx1_reg;
      fx3_reg <= fx2_reg;
      for (int i = 0; i < 16; i++) begin
        if (fx2_reg[i] == fx3_reg[i]) begin
          fx_reg[i] <= fx3_reg[i];
        end
      end
    end
  end

  // steering config; a disallowed IRQ number leaves the field unchanged
  logic [`STEER_W-1:0] steer_reg [NL];
  irq_router_pkg::irq_mode_t mode_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NL; i++) begin
        steer_reg[i] <= `STEER_RESET;
      end
      mode_reg <= irq_router_pkg::MODE_LEGACY;
    end else if (steer_wr) begin
      mode_reg <= irq_router_pkg::irq_mode_t'(mode_adv);
      for (int i = 0; i < NL; i++) begin
        if (ALLOWED[steer_cfg[`STEER_W*i +: `STEER_W]]) begin
          steer_reg[i] <= steer_cfg[`STEER_W*i +: `STEER_W];
        end
      end
    end
  end

  // field value 0 means unrouted, since IRQ 0 is never allowed
  logic [15:0] steered;
  always_comb begin
    steered = '0;
    for (int i = 0; i < NL; i++) begin
      if (ALLOWED[steer_reg[i]] && line_reg[i]) begin
        steered[steer_reg[i]] = 1'b1;
      end
    end
  end

  logic [`ADV_IRQ_COUNT-1:0] irq_next;
  always_comb begin
    irq_next = '0;
    // reserved IRQs carry only their own fixed sources
    irq_next[15:0] = (steered & ~RESERVED) | fx_reg;
    if (mode_reg == irq_router_pkg::MODE_ADVANCED) begin
      irq_next[`ADV_LINE_BASE +: NL] = line_reg;
    end
  end

  logic [`STEER_W*NL-1:0] steer_flat;
  always_comb begin
    for (int i = 0; i < NL; i++) begin
      steer_flat[`STEER_W*i +: `STEER_W] = steer_reg[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_out     <= '0;
      line_state  <= '0;
      steer_state <= '0;
      mode_state  <= 1'b0;
    end else begin
      irq_out     <= irq_next;
      line_state  <= line_reg;
      steer_state <= steer_flat;
      mode_state  <= mode_reg;
    end
  end

endmodule

// ==== irq_router_defs.svh ====
`ifndef IRQ_ROUTER_DEFS_SVH
`define IRQ_ROUTER_DEFS_SVH

`define LEGACY_IRQ_COUNT 16
`define ADV_IRQ_COUNT    24
`define LINE_COUNT       8
`define ADV_LINE_BASE    16
`define STEER_W          4
`define STEER_RESET      4'h0
`define STEER_ALLOWED    16'hDEF8
`define CARD_SLOT_COUNT  2
`define CARD_PIN_COUNT   4
`define IRQ_CASCADE      2
`define IRQ_TIMER        0
`define IRQ_KEYBOARD     1
`define IRQ_RTC          8
`define IRQ_COPROC       13
`define RESERVED_MASK    16'h2107

`endif

// ==== irq_router_pkg.sv ====
package irq_router_pkg;
  typedef enum logic [0:0] {
    MODE_LEGACY   = 1'b0,
    MODE_ADVANCED = 1'b1
  } irq_mode_t;
endpackage

// ==== router_asserts.sv ====
`timescale 1ns/1ps
module router_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  slot1_int,
  input wire logic [3:0]  slot2_int,
  input wire logic [15:0] fixed_irq,
  input wire logic [31:0] steer_cfg,
  input wire logic        steer_wr,
  input wire logic        mode_adv,
  input wire logic [23:0] irq_out,
  input wire logic [7:0]  line_state,
  input wire logic [31:0] steer_state,
  input wire logic        mode_state
);
  logic ok_a;
  assign ok_a = ((16'hDEF8 >> steer_cfg[3:0]) & 16'h0001) != 16'h0000;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_legacy_hi: assert property (!mode_state && !$past(mode_state) |->
    irq_out[23:16] == 8'h00) else $error("upper irq in legacy");
  chk_adv_direct: assert property (mode_state && $past(mode_state) |->
    irq_out[23:16] == line_state) else $error("upper irq mismatch");
  chk_cascade_free: assert property (!fixed_irq[2] [*6] |-> !irq_out[2])
    else $error("irq 2 driven");
  chk_fixed_only: assert property ((fixed_irq & 16'h2103) == 16'h0000 [*6] |->
    (irq_out[15:0] & 16'h2103) == 16'h0000) else $error("reserved irq driven");
  chk_slot_wiring: assert property (slot1_int[3] [*4] |-> ##5 line_state[4])
    else $error("slot1 D not on e");
  chk_line_share: assert property (slot2_int[1] [*4] |-> ##5 line_state[5])
    else $error("slot2 B not on f");
  chk_steer_load: assert property (steer_wr |-> ##2 steer_state[3:0] == ($past(ok_a, 2) ?
    $past(steer_cfg[3:0], 2) : $past(steer_state[3:0]))) else $error("line a field");
  chk_mode_load: assert property (steer_wr |-> ##2 mode_state == $past(mode_adv, 2))
    else $error("mode not loaded");
  cov_adv: cover property (mode_state && line_state[7]);
  cov_refuse: cover property (steer_wr && !ok_a);
  cov_share: cover property (line_state[4] && line_state[5]);
endmodule
bind pci_interrupt_line_router router_asserts chk (.clk, .rst, .slot1_int, .slot2_int,
  .fixed_irq, .steer_cfg, .steer_wr, .mode_adv, .irq_out, .line_state, .steer_state, .mode_state);

// ==== card_sources.sv ====
`timescale 1ns/1ps
module card_sources (
  input  wire logic        clk, // bench clock
  input  wire logic [16:0] pat, // requested levels
  output logic      [16:0] src  // onboard, serial, slot2, slot1
);
  initial src = 17'h00000;
  always @(negedge clk) src <= pat; // level held until the card changes it
endmodule

// ==== tb_pci_interrupt_line_router.sv ====
`timescale 1ns/1ps
module tb_pci_interrupt_line_router;
  logic        clk = 0, rst = 1, steer_wr = 0, mode_adv = 0, mode_m = 0, mode_state;
  logic [16:0] pat = 17'h00000, src;
  logic [23:0] onboard_sel = 24'h000000, irq_out;
  logic [15:0] fixed_irq = 16'h0000;
  logic [31:0] steer_cfg = 32'h00000000, steer_m = 32'h00000000, steer_state, q[$];
  logic [32:0] qc[$];
  logic [7:0]  line_state;
  int          errors = 0, compares = 0;
  event        ev;
  card_sources far (.clk(clk), .pat(pat), .src(src));
  pci_interrupt_line_router uut (.clk(clk), .rst(rst), .slot1_int(src[3:0]), .slot2_int(src[7:4]),
    .serial_bus_int(src[8]), .onboard_int(src[16:9]), .onboard_sel(onboard_sel),
    .mode_adv(mode_adv), .steer_cfg(steer_cfg), .steer_wr(steer_wr), .fixed_irq(fixed_irq),
    .irq_out(irq_out), .line_state(line_state), .steer_state(steer_state),
    .mode_state(mode_state));
  initial forever #5 clk = ~clk;
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp_out(input logic [31:0] exp);
    compares++;
    if ({irq_out, line_state} !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, {irq_out, line_state}, exp);
    end
  endtask
  task automatic cmp_cfg(input logic [32:0] exp);
    compares++;
    if ({mode_state, steer_state} !== exp) begin
      errors++;
      $display("MISMATCH %0t cfg got %h exp %h", $time, {mode_state, steer_state}, exp);
    end
  endtask
  function automatic logic [31:0] exp_out();
    logic [7:0]  ln;
    logic [23:0] iq;
    ln = {src[2] | src[7], src[1] | src[4], src[0] | src[5], src[3] | src[6], 2'b00, src[8], 1'b0};
    for (int i = 0; i < 8; i++) ln[onboard_sel[3*i+:3]] |= src[9+i];
    iq = {mode_m ? ln : 8'h00, fixed_irq};
    for (int i = 0; i < 8; i++) if (steer_m[4*i+:4] != 4'h0) iq[steer_m[4*i+:4]] |= ln[i];
    return {iq, ln};
  endfunction
  always @(ev) cmp_out(q.pop_front());
  always @(ev) cmp_cfg(qc.pop_front());
  initial begin
    #20000 errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'h5601));
    repeat (3) @(negedge clk);
    rst = 0;
    for (int t = 0; t < 80; t++) begin
      if (t % 10 == 0) begin
        for (int i = 0; i < 8; i++) steer_cfg[4*i+:4] = 4'(44'hFECBA976543 >> 4*($urandom % 11));
        if (t % 20 == 0) steer_cfg[3:0] = t[5] ? 4'h8 : 4'h2;
        mode_adv = t[4];
        steer_wr = 1;
        for (int i = 0; i < 8; i++) if ((16'hDEF8 >> steer_cfg[4*i+:4]) & 1) steer_m[4*i+:4] = steer_cfg[4*i+:4];
        mode_m = t[4];
        @(negedge clk) steer_wr = 0;
      end
      pat = 17'($urandom);
      onboard_sel = 24'($urandom);
      fixed_irq = 16'($urandom);
      repeat (8) @(negedge clk);
      q.push_back(exp_out());
      qc.push_back({mode_m, steer_m});
      -> ev;
    end
    tally_and_finish();
  end
endmodule
